// ===== core/cirq_cfg.svh
`ifndef CIRQ_CFG_SVH
`define CIRQ_CFG_SVH

// ****************************************************************
// Route encodings and reset defaults
// ****************************************************************
// Interrupt route codes: one hot over three host request lines
`define CIRQ_IRQ_ROUTE_L10 3'h1
`define CIRQ_IRQ_ROUTE_L11 3'h2
`define CIRQ_IRQ_ROUTE_L12 3'h4
// Default interrupt route is the highest of the three lines
`define CIRQ_IRQ_ROUTE_DEFAULT 3'h4
// DMA route codes: one hot over three channels, none by default
`define CIRQ_DMA_ROUTE_CH5 3'h1
`define CIRQ_DMA_ROUTE_CH6 3'h2
`define CIRQ_DMA_ROUTE_CH7 3'h4
`define CIRQ_DMA_ROUTE_DEFAULT 3'h0
// Shared mode off by default
`define CIRQ_SHARED_DEFAULT 1'h0
// Cycles the request line stays low before a new rise in normal mode
`define CIRQ_LOW_GAP_CYCLES 2'h1

`endif

// ===== core/cirq_pkg.sv
package cirq_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	// Static configuration presented as strap-like inputs
	typedef struct packed {
		logic [2:0] irq_route; // One hot interrupt route
		logic shared; // High selects shared mode
		logic [2:0] dma_route; // One hot DMA route, zero for none
	} cirq_cfg_type;

	// One request-pin triple, oe is active low
	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe_n;
	} cirq_pins_type;

	// Request sequencer states
	typedef enum logic [1:0] {
		CIRQ_IDLE,
		CIRQ_ACTIVE,
		CIRQ_GAP
	} cirq_state_type;

endpackage

// ===== core/cirq_request.sv
`timescale 1ns/100ps
`include "cirq_cfg.svh"

// Functional notes
// - Conversion done raises request on selected line
// - Config selects normal or shared mode
// - Normal mode: always driven, rising edge requests
// - Normal mode: return low before every new rise
// - Normal mode idles low between requests
// - Shared mode: enable driver with data high
// - Shared mode: driver released when nothing pending
// - Conversion done raises DMA request if routed
module cirq_request (
	input wire logic clk,
	input wire logic rstn,
	input wire cirq_pkg::cirq_cfg_type cfg, // Held stable during operation
	input wire logic conv_done, // One-cycle pulse per conversion
	input wire logic irq_ack, // Host service acknowledge pulse
	input wire logic [2:0] dma_ack, // DMA acknowledge per channel
	output cirq_pkg::cirq_pins_type irq_pins, // Three host request lines
	output logic [2:0] dma_req, // Per-channel DMA requests
	output logic pending // Request outstanding
);

	// ****************************************************************
	// Request sequencer
	// ****************************************************************
	// Only one completion is queued while a request is in service; a
	// further one inside that window merges with the queued one
	cirq_pkg::cirq_state_type state_q, state_d;
	logic again_q, again_d; // Conversion seen while busy; not lost
	logic [1:0] gap_q, gap_d; // Low-time counter before next rise

	// Next-state logic for the interrupt request
	always_comb begin
		state_d = state_q;
		again_d = again_q;
		gap_d = gap_q;
		case (state_q)
			cirq_pkg::CIRQ_IDLE: begin
				// Conversion raises the request
				if (conv_done) begin
					state_d = cirq_pkg::CIRQ_ACTIVE;
				end
			end
			cirq_pkg::CIRQ_ACTIVE: begin
				// A completion during service is kept for a new edge
				if (conv_done) begin
					again_d = 1'b1;
				end
				// Service withdraws the request
				if (irq_ack) begin
					state_d = cirq_pkg::CIRQ_GAP;
					gap_d = `CIRQ_LOW_GAP_CYCLES;
				end
			end
			cirq_pkg::CIRQ_GAP: begin
				// Line held low so the next rise is fresh
				if (conv_done) begin
					again_d = 1'b1;
				end
				if (gap_q > 2'h1) begin
					gap_d = gap_q - 2'h1;
				end else if (again_q || conv_done) begin
					state_d = cirq_pkg::CIRQ_ACTIVE;
					again_d = 1'b0;
				end else begin
					state_d = cirq_pkg::CIRQ_IDLE;
				end
			end
			default: begin
				state_d = cirq_pkg::CIRQ_IDLE;
				again_d = 1'b0;
				gap_d = 2'h0;
			end
		endcase
	end

	// Registers of the sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= cirq_pkg::CIRQ_IDLE;
			again_q <= 1'b0;
			gap_q <= 2'h0;
		end else begin
			state_q <= state_d;
			again_q <= again_d;
			gap_q <= gap_d;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	cirq_pkg::cirq_pins_type pins_q, pins_d;
	logic [2:0] dma_q, dma_d;

	// Drive levels from state; outputs are registered
	always_comb begin
		logic act;
		act = (state_d == cirq_pkg::CIRQ_ACTIVE);
		pins_d.o = 3'h0;
		pins_d.oe_n = 3'h7;
		if (cfg.shared) begin
			// Data fixed high, enable only while pending
			pins_d.o = cfg.irq_route;
			// Released otherwise so others may signal
			pins_d.oe_n = act ? ~cfg.irq_route : 3'h7;
		end else begin
			// Totem pole always driven, idles low
			pins_d.oe_n = ~cfg.irq_route;
			pins_d.o = act ? cfg.irq_route : 3'h0;
		end
		// DMA request held until acknowledged; set wins
		dma_d = (dma_q & ~dma_ack) | (conv_done ? cfg.dma_route : 3'h0);
	end

	// Output registers; undriven until reset releases
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pins_q.o <= 3'h0;
			pins_q.oe_n <= 3'h7;
			dma_q <= 3'h0;
		end else begin
			pins_q <= pins_d;
			dma_q <= dma_d;
		end
	end

	// Pins and DMA requests leave straight from flip-flops, so the host
	// never sees a glitch while the sequencer changes state
	assign irq_pins = pins_q;
	assign dma_req = dma_q;
	assign pending = (state_q == cirq_pkg::CIRQ_ACTIVE) || again_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	// Requests not yet acknowledged, per DMA channel
	logic [2:0] dma_hold;
	assign dma_hold = dma_req & ~dma_ack;

	// Pins follow the next state, so a request shows one edge later
	a_conv_raises: assert property (
		@(posedge clk) disable iff (!rstn)
		(state_q == cirq_pkg::CIRQ_IDLE && conv_done) |=>
		((irq_pins.o & cfg.irq_route) == cfg.irq_route &&
		(irq_pins.oe_n & cfg.irq_route) == 3'h0))
		else $error("request not raised after conversion");
	// Only the selected line is ever enabled; the rest stay released
	a_one_line: assert property (
		@(posedge clk) disable iff (!rstn)
		((irq_pins.oe_n | cfg.irq_route) == 3'h7))
		else $error("unselected request line driven");
	// Normal mode keeps the line driven whatever the sequencer does
	a_normal_driven: assert property (
		@(posedge clk) disable iff (!rstn)
		(!cfg.shared && $stable(cfg)) |=> ##1
		(irq_pins.oe_n == ~cfg.irq_route))
		else $error("normal mode line not driven");
	// The line falls right after service, before any queued rise
	a_fresh_edge: assert property (
		@(posedge clk) disable iff (!rstn)
		(!cfg.shared && state_q == cirq_pkg::CIRQ_ACTIVE && irq_ack)
		|=> ((irq_pins.o & cfg.irq_route) == 3'h0))
		else $error("line not returned low before new request");
	// Shared data input is tied high; only the enable ever moves
	a_shared_high: assert property (
		@(posedge clk) disable iff (!rstn)
		(cfg.shared && $stable(cfg)) |=> ##1
		((irq_pins.o & cfg.irq_route) == cfg.irq_route))
		else $error("shared driver data not high");
	// Nothing pending in shared mode leaves the driver floating
	a_shared_release: assert property (
		@(posedge clk) disable iff (!rstn)
		(cfg.shared && state_q == cirq_pkg::CIRQ_IDLE && !conv_done)
		|=> (irq_pins.oe_n == 3'h7))
		else $error("shared driver not released when idle");
	// Idle level in normal mode is the customary low one
	a_idle_low: assert property (
		@(posedge clk) disable iff (!rstn)
		(!cfg.shared && state_q == cirq_pkg::CIRQ_IDLE && !conv_done)
		|=> (irq_pins.o == 3'h0))
		else $error("normal mode idle level not low");
	// A completion asks every routed channel for a transfer
	a_dma_req: assert property (
		@(posedge clk) disable iff (!rstn)
		conv_done |=> ((dma_req & cfg.dma_route) == cfg.dma_route))
		else $error("DMA request missing after conversion");
	// A DMA request stands until its own channel acknowledges
	a_dma_hold: assert property (
		@(posedge clk) disable iff (!rstn)
		(dma_hold != 3'h0) |=>
		((dma_req & $past(dma_hold)) == $past(dma_hold)))
		else $error("DMA request dropped before acknowledge");
	// An acknowledge with no new completion clears its channel
	a_dma_clear: assert property (
		@(posedge clk) disable iff (!rstn)
		(dma_ack != 3'h0 && !conv_done) |=>
		((dma_req & $past(dma_ack)) == 3'h0))
		else $error("DMA request not cleared by acknowledge");
	// Channels left unrouted never see a request
	a_dma_route_only: assert property (
		@(posedge clk) disable iff (!rstn)
		((dma_req & ~cfg.dma_route) == 3'h0))
		else $error("DMA request on an unrouted channel");
	// Service moves the sequencer out of the active state
	a_ack_withdraw: assert property (
		@(posedge clk) disable iff (!rstn)
		(state_q == cirq_pkg::CIRQ_ACTIVE && irq_ack)
		|=> (state_q == cirq_pkg::CIRQ_GAP))
		else $error("request not withdrawn on acknowledge");
	// Service in shared mode floats the driver at once
	a_shared_withdraw: assert property (
		@(posedge clk) disable iff (!rstn)
		(cfg.shared && state_q == cirq_pkg::CIRQ_ACTIVE && irq_ack)
		|=> (irq_pins.oe_n == 3'h7))
		else $error("shared driver not released after service");
	// Shared mode must not hold the enable while idle
	a_mode_select: assert property (
		@(posedge clk) disable iff (!rstn)
		(cfg.shared && state_q == cirq_pkg::CIRQ_IDLE && !conv_done
		&& $stable(cfg)) |=> ((irq_pins.oe_n & cfg.irq_route) != 3'h0))
		else $error("shared mode drives while idle");

endmodule

// ===== dv/cirq_host_model.sv
`timescale 1ns/100ps

// ****
// Host interrupt and DMA controller model
// ****
module cirq_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic shared, // Pull-down fitted on the lines
	input var int ack_wait, // Service latency, in cycles
	input wire cirq_pkg::cirq_pins_type pins,
	input wire logic [2:0] dma_req,
	output logic [2:0] line, // Resolved line levels
	output logic irq_ack,
	output logic [2:0] dma_ack,
	output int n_req // Requests the host has seen
);
	logic [2:0] line_q; // Levels at the last edge
	int wait_q; // >0 servicing, <0 settling after an ack
	logic seen;
	// A released line rests low on the pull-down, else on the pull-up
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			line[i] = !pins.oe_n[i] ? pins.o[i] : !shared;
		end
		seen = shared ? |line : |(line & ~line_q);
	end
	// Settling window stops a still-high shared line counting twice
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			line_q <= line;
			wait_q <= 0;
			n_req <= 0;
			irq_ack <= 1'h0;
			dma_ack <= 3'h0;
		end else begin
			line_q <= line;
			irq_ack <= 1'h0;
			dma_ack <= dma_req & ~dma_ack;
			if (wait_q < 0) begin
				wait_q <= wait_q + 1;
			end else if (wait_q == ack_wait && wait_q > 0) begin
				irq_ack <= 1'h1;
				wait_q <= -1;
			end else if (wait_q > 0) begin
				wait_q <= wait_q + 1;
			end else if (seen) begin
				n_req <= n_req + 1;
				wait_q <= 1;
			end
		end
	end
endmodule

// ===== dv/tb_conversion_irq_dma_request.sv
`timescale 1ns/100ps
`include "cirq_cfg.svh"

module tb_conversion_irq_dma_request;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic conv_done = 1'h0;
	cirq_pkg::cirq_cfg_type cfg = '0;
	cirq_pkg::cirq_pins_type irq_pins;
	logic [2:0] dma_req, dma_ack, line, dma_seen;
	logic irq_ack, pending;
	int ack_wait = 1;
	int n_req, n_mismatch = 0, check_count = 0, cycles = 0;
	always #12.5 clk = ~clk;
	cirq_request dut (.clk(clk), .rstn(rstn), .cfg(cfg),
		.conv_done(conv_done), .irq_ack(irq_ack), .dma_ack(dma_ack),
		.irq_pins(irq_pins), .dma_req(dma_req), .pending(pending));
	cirq_host_model host (.clk(clk), .rstn(rstn), .shared(cfg.shared),
		.ack_wait(ack_wait), .pins(irq_pins), .dma_req(dma_req),
		.line(line), .irq_ack(irq_ack), .dma_ack(dma_ack), .n_req(n_req));
	// Sticky record of DMA channels asked for since reset
	always @(posedge clk) begin
		dma_seen <= !rstn ? 3'h0 : dma_seen | dma_req;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Reset also loads the configuration under test; the task itself checks nothing
	task automatic reset_dut(input logic [2:0] irq, sh, dma);
		@(posedge clk);
		#1 rstn = 1'h0;
		cfg = '{irq_route: irq, shared: sh[0], dma_route: dma};
		repeat (20) @(posedge clk);
		#1 rstn = 1'h1;
		repeat (2) @(posedge clk);
		#2;
	endtask
	task automatic pulse(input int n, output int base);
		base = n_req;
		@(posedge clk);
		#1 conv_done = 1'h1;
		repeat (n) @(posedge clk);
		#1 conv_done = 1'h0;
		for (int k = 0; k < 40 && n_req < base + n; k++) @(posedge clk);
		#2;
	endtask
	task automatic t_defaults();
		reset_dut(`CIRQ_IRQ_ROUTE_DEFAULT, `CIRQ_SHARED_DEFAULT,
			`CIRQ_DMA_ROUTE_DEFAULT);
		check("idle drive", {irq_pins.o[2], irq_pins.oe_n[2]}, 8'h0);
		check("no dma", 8'(dma_req), 8'h0);
	endtask
	task automatic t_normal(input int i);
		int b;
		reset_dut(3'h1 << i, 3'h0, 3'h1 << i);
		pulse(1, b);
		check("irq rise", 8'(n_req - b), 8'h1);
		check("line high", 8'(line[i]), 8'h1);
		check("one line", 8'(irq_pins.oe_n ^ (3'h1 << i)), 8'h7);
		check("dma", 8'(dma_seen), 8'h1 << i);
		repeat (8) @(posedge clk);
		check("withdrawn", {line[i], pending}, 8'h0);
		check("dma done", 8'(dma_req), 8'h0);
	endtask
	task automatic t_back();
		int b;
		ack_wait = 6;
		reset_dut(3'h2, 3'h0, 3'h0);
		pulse(2, b);
		check("two edges", 8'(n_req - b), 8'h2);
		ack_wait = 1;
	endtask
	task automatic t_shared();
		int b;
		reset_dut(3'h2, 3'h1, 3'h0);
		check("released", 8'(irq_pins.oe_n), 8'h7);
		pulse(1, b);
		check("drive hi", {irq_pins.o[1], irq_pins.oe_n[1]}, 8'h2);
		check("shared req", 8'(n_req - b), 8'h1);
		repeat (8) @(posedge clk);
		check("release", 8'(irq_pins.oe_n), 8'h7);
	endtask
	initial begin
		t_defaults();
		for (int i = 0; i < 3; i++) t_normal(i);
		t_back();
		t_shared();
		end_of_test();
	end
endmodule
